// file: design/ldcr_top.sv
`timescale 1ns/100ps
`include "ldcr_cfg.svh"
module ldcr_top
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_WR,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  output logic [7:0] O_RDATA,
  input wire logic I_CMD_DISP,
  input wire logic I_CMD_SCROLL,
  input wire logic I_PARAM_WR,
  input wire logic I_FRAME,
  input wire logic I_DUAL_PANEL,
  input wire logic I_PSAVE_ENTER,
  input wire logic I_MEM_WR,
  input wire logic I_MEM_RD,
  output logic O_CURSOR_ADV,
  output logic O_CURSOR_EN,
  output logic [15:0] O_FIRST_BLOCK_START,
  output ldcr_pkg::ldcr_vis_s O_VIS
);
  logic [7:0] disp_on;
  logic [7:0] attr;
  logic [7:0] b1_lo;
  logic [7:0] b1_hi;
  logic [15:0] first_block_start;
  logic cur_en;
  logic [15:0] param_ptr;
  logic scroll_mode;
  logic [7:0] rdata;
  logic [7:0] next_disp_on;
  logic [7:0] next_attr;
  logic [7:0] next_b1_lo;
  logic [7:0] next_b1_hi;
  logic [15:0] next_first_block_start;
  logic next_cur_en;
  logic [15:0] next_param_ptr;
  logic next_scroll_mode;
  logic [7:0] next_rdata;
  logic [15:0] waddr;
  logic wen;
  logic [5:0] fcount;
  logic [6:0] cur_phase;
  ldcr_pkg::ldcr_vis_s vis;
  ldcr_pkg::ldcr_vis_s next_vis;
  ldcr_flash u_flash
  (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_frame(I_FRAME),
    .o_count(fcount)
  );
  // Direct write or indirect parameter byte both land here
  always_comb
  begin
    wen = I_WR | I_PARAM_WR;
    waddr = I_PARAM_WR ? param_ptr : I_ADDR;
  end
  function automatic logic block_on(input logic [1:0] a, input logic [5:0] c);
    unique case (ldcr_pkg::ldcr_attr_e'(a))
      ldcr_pkg::LDCR_ATTR_BLANK: block_on = 1'b0;
      ldcr_pkg::LDCR_ATTR_STEADY: block_on = 1'b1;
      // Half duty from the counter bit
      ldcr_pkg::LDCR_ATTR_FLASH_A: block_on = ~c[$clog2(`LDCR_DIV_MID) - 1];
      ldcr_pkg::LDCR_ATTR_FLASH_B: block_on = ~c[$clog2(`LDCR_DIV_FAST) - 1];
    endcase
  endfunction
  always_comb
  begin
    next_disp_on = disp_on;
    next_attr = attr;
    next_b1_lo = b1_lo;
    next_b1_hi = b1_hi;
    next_first_block_start = first_block_start;
    next_cur_en = cur_en;
    next_param_ptr = param_ptr;
    next_scroll_mode = scroll_mode;
    next_rdata = rdata;
    if (I_CMD_DISP)
    begin
      next_param_ptr = `LDCR_OFS_ATTR;
      next_scroll_mode = 1'b0;
      // Command byte bit 0 switches the display; a same-cycle direct write wins
      next_disp_on = {7'h00, I_WDATA[`LDCR_DISP_EN_BIT]};
    end
    else if (I_CMD_SCROLL)
    begin
      next_param_ptr = `LDCR_OFS_B1_LO;
      next_scroll_mode = 1'b1;
    end
    else if (I_PARAM_WR && scroll_mode && param_ptr != `LDCR_OFS_SCROLL_LAST)
    begin
      next_param_ptr = param_ptr + 16'h0001;
    end
    if (wen)
    begin
      unique case (waddr)
        `LDCR_OFS_DISP_ON: next_disp_on = {7'h00, I_WDATA[`LDCR_DISP_EN_BIT]};
        `LDCR_OFS_ATTR: next_attr = I_WDATA;
        `LDCR_OFS_B1_LO: next_b1_lo = I_WDATA;
        `LDCR_OFS_B1_HI:
        begin
          next_b1_hi = I_WDATA;
          next_first_block_start = {I_WDATA, b1_lo};
        end
        default: next_rdata = rdata;
      endcase
    end
    if (I_PSAVE_ENTER)
    begin
      next_disp_on = `LDCR_RST_REG;
    end
    if (I_MEM_WR)
    begin
      next_cur_en = 1'b1;
    end
    unique case (I_ADDR)
      `LDCR_OFS_DISP_ON: next_rdata = disp_on;
      `LDCR_OFS_ATTR: next_rdata = attr;
      `LDCR_OFS_B1_LO: next_rdata = b1_lo;
      `LDCR_OFS_B1_HI: next_rdata = b1_hi;
      default: next_rdata = 8'h00;
    endcase
  end
  // Cursor phase in 1/100 of a flash period: the slowest for LDCR_ATTR_FLASH_B, the middle one otherwise
  always_comb
  begin
    if (attr[`LDCR_CUR_MSB:`LDCR_CUR_LSB] == ldcr_pkg::LDCR_ATTR_FLASH_B)
    begin
      cur_phase = 7'((fcount * 100) / `LDCR_DIV_SLOW);
    end
    else
    begin
      cur_phase = 7'((fcount[4:0] * 100) / `LDCR_DIV_MID);
    end
  end
  always_comb
  begin
    next_vis.block3 = block_on(attr[`LDCR_B3_MSB:`LDCR_B3_LSB], fcount);
    next_vis.block2 = block_on(attr[`LDCR_B2_MSB:`LDCR_B2_LSB], fcount);
    next_vis.block4 = I_DUAL_PANEL & next_vis.block2;
    next_vis.block1 = block_on(attr[`LDCR_B1_MSB:`LDCR_B1_LSB], fcount);
    next_vis.cursor = cur_en & ((attr[1:0] == ldcr_pkg::LDCR_ATTR_STEADY) |
      (attr[1] & (cur_phase < 7'(`LDCR_CUR_ON_PCT))));
    if (!disp_on[`LDCR_DISP_EN_BIT])
    begin
      next_vis = '0;
    end
  end
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      disp_on <= `LDCR_RST_REG;
      attr <= `LDCR_RST_REG;
      b1_lo <= `LDCR_RST_REG;
      b1_hi <= `LDCR_RST_REG;
      first_block_start <= 16'h0000;
      cur_en <= 1'b0;
      param_ptr <= `LDCR_OFS_ATTR;
      scroll_mode <= 1'b0;
      rdata <= 8'h00;
      vis <= '0;
    end
    else
    begin
      disp_on <= next_disp_on;
      attr <= next_attr;
      b1_lo <= next_b1_lo;
      b1_hi <= next_b1_hi;
      first_block_start <= next_first_block_start;
      cur_en <= next_cur_en;
      param_ptr <= next_param_ptr;
      scroll_mode <= next_scroll_mode;
      rdata <= next_rdata;
      vis <= next_vis;
    end
  end
  assign O_CURSOR_ADV = I_MEM_WR | I_MEM_RD;
  assign O_CURSOR_EN = cur_en;
  assign O_RDATA = rdata;
  assign O_FIRST_BLOCK_START = first_block_start;
  assign O_VIS = vis;

  property p_master_off;
    @(posedge I_CLK) disable iff (!I_RST_B) !disp_on[0] |=> vis == '0;
  endproperty
  a_master_off: assert property (p_master_off) else $error("output shown while disabled");
  property p_psave;
    @(posedge I_CLK) disable iff (!I_RST_B) I_PSAVE_ENTER |=> !disp_on[0];
  endproperty
  a_psave: assert property (p_psave) else $error("power save left display on");
  property p_hi_commit;
    @(posedge I_CLK) disable iff (!I_RST_B)
      (wen && waddr == `LDCR_OFS_B1_LO) |=> $stable(first_block_start);
  endproperty
  a_hi_commit: assert property (p_hi_commit) else $error("start moved on low byte");
  property p_addr16;
    @(posedge I_CLK) disable iff (!I_RST_B)
      (wen && waddr == `LDCR_OFS_B1_HI) |=> first_block_start == {b1_hi, b1_lo};
  endproperty
  a_addr16: assert property (p_addr16) else $error("start address mismatch");
  property p_wr_en;
    @(posedge I_CLK) disable iff (!I_RST_B) I_MEM_WR |=> cur_en;
  endproperty
  a_wr_en: assert property (p_wr_en) else $error("write kept cursor off");
  property p_rd_keep;
    @(posedge I_CLK) disable iff (!I_RST_B) (I_MEM_RD && !I_MEM_WR && !cur_en) |=> !cur_en;
  endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("read enabled cursor");
  property p_blank;
    @(posedge I_CLK) disable iff (!I_RST_B) attr[3:2] == 2'b00 |=> !vis.block1;
  endproperty
  a_blank: assert property (p_blank) else $error("blank block shown");
  property p_dual;
    @(posedge I_CLK) disable iff (!I_RST_B) I_DUAL_PANEL |=> vis.block4 == vis.block2;
  endproperty
  a_dual: assert property (p_dual) else $error("block four differs");
  sequence s_disp_param;
    I_CMD_DISP ##1 (I_PARAM_WR && !I_CMD_DISP && !I_CMD_SCROLL);
  endsequence
  property p_disp_cmd;
    @(posedge I_CLK) disable iff (!I_RST_B) s_disp_param |=> attr == $past(I_WDATA);
  endproperty
  a_disp_cmd: assert property (p_disp_cmd) else $error("display command param lost");
  property p_disp_state;
    @(posedge I_CLK) disable iff (!I_RST_B)
      (I_CMD_DISP && !I_PSAVE_ENTER && !wen) |=> disp_on[0] == $past(I_WDATA[`LDCR_DISP_EN_BIT]);
  endproperty
  a_disp_state: assert property (p_disp_state) else $error("display command state lost");
endmodule

// file: inc/ldcr_cfg.svh
`ifndef LDCR_CFG_SVH
`define LDCR_CFG_SVH
`define LDCR_OFS_DISP_ON 16'h8009
`define LDCR_OFS_ATTR 16'h800a
`define LDCR_OFS_B1_LO 16'h800b
`define LDCR_OFS_B1_HI 16'h800c
`define LDCR_OFS_SCROLL_LAST 16'h8014
`define LDCR_RST_REG 8'h00
`define LDCR_DISP_EN_BIT 0
`define LDCR_B3_MSB 7
`define LDCR_B3_LSB 6
`define LDCR_B2_MSB 5
`define LDCR_B2_LSB 4
`define LDCR_B1_MSB 3
`define LDCR_B1_LSB 2
`define LDCR_CUR_MSB 1
`define LDCR_CUR_LSB 0
`define LDCR_DIV_FAST 4
`define LDCR_DIV_MID 32
`define LDCR_DIV_SLOW 64
`define LDCR_CUR_ON_PCT 70
`endif

// file: inc/ldcr_pkg.sv
package ldcr_pkg;
  typedef enum logic [1:0]
  {
    LDCR_ATTR_BLANK = 2'b00,
    LDCR_ATTR_STEADY = 2'b01,
    LDCR_ATTR_FLASH_A = 2'b10,
    LDCR_ATTR_FLASH_B = 2'b11
  } ldcr_attr_e;
  typedef struct packed
  {
    logic block1;
    logic block2;
    logic block3;
    logic block4;
    logic cursor;
  } ldcr_vis_s;
endpackage

// file: design/ldcr_flash.sv
`timescale 1ns/100ps
`include "ldcr_cfg.svh"
module ldcr_flash
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_frame,
  output logic [5:0] o_count
);
  logic [5:0] count;
  logic [5:0] next_count;
  always_comb
  begin
    next_count = i_frame ? count + 6'h01 : count;
  end
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      count <= 6'h00;
    end
    else
    begin
      count <= next_count;
    end
  end
  assign o_count = count;
endmodule

// file: bench/ldcr_host.sv
`timescale 1ns/100ps
module ldcr_host
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [5:0] o_stb,
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata
);
  // Strobes: write, display cmd, scroll cmd, param, mem write, mem read
  initial {o_stb, o_addr, o_wdata} = '0;
  // Data inverted on release so a stale byte is never mistaken for a held one
  task automatic put(input logic [5:0] s, input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {o_stb, o_addr, o_wdata} = {s, a, d};
    @(negedge i_clk);
    {o_stb, o_wdata} = {6'h00, ~d};
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    @(negedge i_clk);
    d = i_rdata;
  endtask
  task automatic disp(input logic on, input logic [7:0] d);
    @(negedge i_clk);
    {o_stb, o_addr, o_wdata} = {6'h10, 16'h800a, 7'h00, on};
    @(negedge i_clk);
    {o_stb, o_wdata} = {6'h04, d};
    @(negedge i_clk);
    {o_stb, o_wdata} = {6'h00, ~d};
  endtask
  task automatic scroll(input logic [7:0] lo, input logic [7:0] hi);
    put(6'h08, 16'h800b, 8'h00);
    put(6'h04, 16'h800b, lo);
    put(6'h04, 16'h800c, hi);
  endtask
endmodule

// file: bench/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic frame = 1'b0;
  logic dual = 1'b0;
  logic psave = 1'b0;
  logic adv, cen, prev;
  logic [5:0] stb;
  logic [15:0] addr, start;
  logic [7:0] wdata, rdata, d, e;
  ldcr_pkg::ldcr_vis_s vis;
  int num_errors = 0;
  int num_checks = 0;
  int m_en = 0;
  int m_attr = 0;
  int m_cur = 0;
  int m_start = 0;
  int n_adv = 0;
  int i, n_on, n_cur, n_tog, n_eq;
  always #5 clk = ~clk;
  always @(posedge clk) if (adv === 1'b1) n_adv++;
  ldcr_host host (.i_clk(clk), .i_rdata(rdata), .o_stb(stb), .o_addr(addr), .o_wdata(wdata));
  ldcr_top i_ldcr_top (.I_CLK(clk), .I_RST_B(rst_b), .I_WR(stb[5]), .I_ADDR(addr), .I_WDATA(wdata),
    .O_RDATA(rdata), .I_CMD_DISP(stb[4]), .I_CMD_SCROLL(stb[3]), .I_PARAM_WR(stb[2]), .I_FRAME(frame),
    .I_DUAL_PANEL(dual), .I_PSAVE_ENTER(psave), .I_MEM_WR(stb[1]), .I_MEM_RD(stb[0]),
    .O_CURSOR_ADV(adv), .O_CURSOR_EN(cen), .O_FIRST_BLOCK_START(start), .O_VIS(vis));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic w(input logic [15:0] a, input int v);
    host.put(6'h20, a, 8'(v));
  endtask
  // Steady-only model; flashing fields are judged by counts instead
  function automatic logic [4:0] expv();
    logic [7:0] a;
    a = 8'(m_attr);
    if (m_en == 0)
      return 5'h00;
    return {a[3:2] == 2'b01, a[5:4] == 2'b01, a[7:6] == 2'b01, a[5:4] == 2'b01 && dual,
      a[1:0] == 2'b01 && m_cur == 1};
  endfunction
  task automatic end_of_test();
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #300us;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h96fa));
    tick(16);
    rst_b = 1'b1;
    for (i = 16'h8008; i < 16'h800e; i++)
    begin
      host.rd(i[15:0], d);
      chk(d, 8'h00);
    end
    chk(vis, 5'h00);
    host.put(6'h01, 16'h800a, 8'h00);
    tick(1);
    chk(cen, 1'b0);
    host.put(6'h02, 16'h800a, 8'h00);
    m_cur = 1;
    tick(1);
    chk(cen, 1'b1);
    chk(n_adv, 2);
    for (i = 0; i < 24; i++)
    begin
      dual = i[1];
      m_en = $urandom % 2;
      m_attr = $urandom & 8'h55;
      w(16'h8009, m_en);
      w(16'h800a, m_attr);
      tick(2);
      chk(vis, expv());
      host.rd(16'h800a, d);
      chk(d, 8'(m_attr));
    end
    m_en = 1;
    host.disp(1'b1, 8'h55);
    m_attr = 8'h55;
    tick(2);
    chk(vis, expv());
    host.rd(16'h800a, d);
    chk(d, 8'h55);
    psave = 1'b1;
    tick(1);
    psave = 1'b0;
    m_en = 0;
    tick(2);
    chk(vis, 5'h00);
    host.rd(16'h8009, d);
    chk(d, 8'h00);
    host.disp(1'b1, 8'h55);
    host.disp(1'b0, 8'h55);
    tick(2);
    chk(vis, 5'h00);
    d = $urandom;
    e = $urandom;
    w(16'h800b, d);
    tick(2);
    chk(start, 16'(m_start));
    w(16'h800c, e);
    m_start = {e, d};
    tick(1);
    chk(start, 16'(m_start));
    host.scroll(e, d);
    tick(1);
    chk(start, {d, e});
    w(16'h8009, 1);
    for (int k = 0; k < 2; k++)
    begin
      w(16'h800a, k ? 8'haa : 8'hff);
      tick(2);
      {n_on, n_cur, n_tog, n_eq, prev} = '0;
      prev = vis.block1;
      for (i = 0; i < 64; i++)
      begin
        frame = 1'b1;
        tick(1);
        frame = 1'b0;
        tick(2);
        n_on += vis.block1;
        n_cur += vis.cursor;
        n_tog += (vis.block1 != prev);
        n_eq += (vis.block2 == vis.block1 && vis.block3 == vis.block1 && vis.block4 == vis.block1);
        prev = vis.block1;
      end
      chk(n_on, 32);
      chk(n_tog, k ? 4 : 32);
      chk(n_eq, 64);
      chk(n_cur >= 44 && n_cur <= 46, 1'b1);
    end
    end_of_test();
  end
endmodule
